// ---- shared/asc_pkg.sv ----
/*
  Constants for the serial status, data-buffer and baud block.
  Assumes a 32-bit APB bus with each register on one aligned word.
*/
`default_nettype none
package asc_pkg;
  localparam logic [7:0] OFF_DATA   = 8'h18;
  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_CTRL3  = 8'h08;
  localparam logic [7:0] OFF_STAT1  = 8'h0c;
  localparam logic [7:0] OFF_STAT2  = 8'h10;
  localparam logic [7:0] OFF_RATE   = 8'h14;
  localparam int         ST1_TE     = 7;
  localparam int         ST1_TC     = 6;
  localparam int         ST1_RF     = 5;
  localparam int         ST1_IDLE   = 4;
  localparam int         ST1_OR     = 3;
  localparam int         ST1_NF     = 2;
  localparam int         ST1_FE     = 1;
  localparam int         ST1_PE     = 0;
  localparam int         ST2_BK     = 1;
  localparam int         ST2_RP     = 0;
  localparam int         C1_M       = 4;
  localparam int         C1_PEN     = 1;
  localparam int         C1_PTY     = 0;
  localparam int         C2_TX_COMPLETE_IRQ_EN    = 6;
  localparam int         C2_RIE     = 5;
  localparam int         C2_IDLE_LINE_IRQ_EN    = 4;
  localparam int         C2_TE      = 3;
  localparam int         C2_RE      = 2;
  localparam int         C2_SBK     = 0;
  localparam int         C3_R8      = 7;
  localparam int         C3_T8      = 6;
  localparam int         C3_RX_OVERRUN_IRQ_EN    = 3;
  localparam int         C3_RX_NOISE_IRQ_EN    = 2;
  localparam int         C3_RX_FRAMING_IRQ_EN    = 1;
  localparam int         C3_RX_PARITY_IRQ_EN    = 0;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h00;
  localparam int         OVERSAMPLE = 16;
  localparam int         BASE_DIV   = 4;
endpackage
`default_nettype wire

// ---- shared/asc_tick_if.sv ----
/*
  Carries the baud sample tick and rate fields between the main block and
  the divider.  Assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface asc_tick_if;
  logic [1:0] rate_prescale_field;
  logic [2:0] rate_divide_field;
  logic       sample_tick;
  modport ctl (output rate_prescale_field, output rate_divide_field,
               input sample_tick);
  modport gen (input rate_prescale_field, input rate_divide_field,
               output sample_tick);
endinterface
`default_nettype wire

// ---- hdl/asc_baud_gen.sv ----
/*
  Baud divider: makes a one-cycle pulse at sixteen times the bit rate, except at prescale code 2'b11, where it makes none.
  Assumes the sys_clk stands in for the crystal and runs continuously.
*/
`timescale 1ns/10ps
`default_nettype none
module asc_baud_gen (
  input  wire logic    sys_clk,
  input  wire logic    rst_b,
  asc_tick_if.gen      tk
);
  function automatic logic [3:0] prescale(input logic [1:0] code);
    case (code)
      2'b00:   prescale = 4'd1;
      2'b01:   prescale = 4'd3;
      2'b10:   prescale = 4'd4;
      default: prescale = 4'd13;
    endcase
  endfunction

  logic [2:0]  base_q;
  logic [3:0]  pre_q;
  logic [7:0]  div_q;
  logic [7:0]  div_top;
  logic        base_tick;
  logic        pre_tick;

  // The 64 split as four base cycles times sixteen samples per bit.
  assign base_tick = (base_q == 3'(asc_pkg::BASE_DIV - 1));
  assign pre_tick  = base_tick && (pre_q == prescale(tk.rate_prescale_field) - 4'd1);
  assign div_top   = 8'((9'd1 << tk.rate_divide_field) - 9'd1);
  assign tk.sample_tick = pre_tick && (div_q >= div_top);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      base_q <= 3'h0;
    end else if (base_tick) begin
      base_q <= 3'h0;
    end else begin
      base_q <= base_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pre_q <= 4'h0;
    end else if (pre_tick || pre_q >= 4'd12) begin
      pre_q <= 4'h0;
    end else if (base_tick) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      div_q <= 8'h00;
    end else if (tk.sample_tick) begin
      div_q <= 8'h00;
    end else if (pre_tick) begin
      div_q <= div_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/asc_flag.sv ----
/*
  One sticky receive flag with the read-status-then-read-data clear.
  Assumes the arm is a status read seen while the flag is already set.
*/
`timescale 1ns/10ps
`default_nettype none
module asc_flag (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic set_evt,
  input  wire logic stat_rd,
  input  wire logic data_rd,
  output logic      flag_q
);
  logic armed_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (stat_rd) begin
      armed_q <= flag_q;
    end else if (data_rd) begin
      armed_q <= 1'b0;
    end
  end

  // A set in the clearing cycle wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (data_rd && armed_q) begin
      flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/asc_core.sv ----
/*
  Serial status, data buffer and baud block with an APB slave, a simple
  transmitter and a sixteen-times oversampling receiver.
  Assumes one clock, a synchronous rxd input and a single APB master.
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module asc_core (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);
  typedef enum logic [1:0] {
    ASC_TX_IDLE  = 2'b00,
    ASC_TX_START = 2'b01,
    ASC_TX_SHIFT = 2'b11
  } asc_tx_e;

  asc_tick_if tk ();

  logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q, rate_q;
  logic [7:0] rx_data_q, tx_data_q;
  logic       tx_empty_flag_q, tx_complete_flag_q, tx_pend_q;
  logic       wr, rd, hit_data, hit_st1, hit_st2, data_rd, data_wr;
  logic       st1_rd, st2_rd;
  logic [7:0] stat1, stat2;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign hit_data = (paddr == asc_pkg::OFF_DATA);
  assign hit_st1  = (paddr == asc_pkg::OFF_STAT1);
  assign hit_st2  = (paddr == asc_pkg::OFF_STAT2);
  assign data_rd = rd && hit_data;
  assign data_wr = wr && hit_data;
  assign st1_rd  = rd && hit_st1;
  assign st2_rd  = rd && hit_st2;

  always_comb begin
    pslverr = 1'b0;
    if (!(psel && penable)) begin
      pslverr = 1'b0;
    end else if (hit_data || paddr == asc_pkg::OFF_CTRL1
                 || paddr == asc_pkg::OFF_CTRL2
                 || paddr == asc_pkg::OFF_CTRL3
                 || paddr == asc_pkg::OFF_RATE) begin
      pslverr = 1'b0;
    end else if (hit_st1 || hit_st2) begin
      pslverr = pwrite;
    end else begin
      pslverr = 1'b1;
    end
  end

  // Control register writes.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl1_q <= asc_pkg::CTRL_RST;
      ctrl2_q <= asc_pkg::CTRL_RST;
      ctrl3_q <= asc_pkg::CTRL_RST;
      rate_q  <= asc_pkg::RATE_RST;
    end else if (wr && paddr == asc_pkg::OFF_CTRL1) begin
      ctrl1_q <= pwdata[7:0];
    end else if (wr && paddr == asc_pkg::OFF_CTRL2) begin
      ctrl2_q <= pwdata[7:0];
    end else if (wr && paddr == asc_pkg::OFF_CTRL3) begin
      ctrl3_q <= {ctrl3_q[7], pwdata[6:0]};
    end else if (wr && paddr == asc_pkg::OFF_RATE) begin
      rate_q  <= {2'b00, pwdata[5:4], 1'b0, pwdata[2:0]};
    end
  end

  assign tk.rate_prescale_field = rate_q[5:4];
  assign tk.rate_divide_field   = rate_q[2:0];

  asc_baud_gen u_baud (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tk      (tk.gen)
  );

  // Transmitter: bit clock is every sixteenth sample tick.
  asc_tx_e    tx_st_q;
  logic [3:0] tx_sub_q;
  logic [3:0] tx_bit_q;
  logic [10:0] tx_sh_q;
  logic       tx_bit_end, tx_par, tx_nine;
  assign tx_bit_end = tk.sample_tick && (tx_sub_q == 4'hf);
  assign tx_nine = ctrl1_q[asc_pkg::C1_M];
  assign tx_par  = ^tx_data_q ^ (tx_nine & ctrl3_q[asc_pkg::C3_T8])
                   ^ ctrl1_q[asc_pkg::C1_PTY];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_sub_q <= 4'h0;
    end else if (tk.sample_tick) begin
      tx_sub_q <= tx_sub_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (data_wr) begin
      tx_data_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_empty_flag_q <= 1'b1;
      tx_pend_q       <= 1'b0;
    end else if (tx_st_q == ASC_TX_START && tx_bit_end && tx_pend_q) begin
      tx_empty_flag_q <= 1'b1;
      tx_pend_q       <= 1'b0;
    end else if (data_wr) begin
      tx_empty_flag_q <= 1'b0;
      tx_pend_q       <= 1'b1;
    end
  end

  // Work queued waits for the next bit boundary, within 1.5 bit clocks.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_st_q  <= ASC_TX_IDLE;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 11'h7ff;
    end else begin
      case (tx_st_q)
        ASC_TX_IDLE: begin
          if (ctrl2_q[asc_pkg::C2_TE] && (tx_pend_q
              || ctrl2_q[asc_pkg::C2_SBK])) begin
            tx_st_q <= ASC_TX_START;
          end
        end
        ASC_TX_START: begin
          if (tx_bit_end) begin
            tx_st_q  <= ASC_TX_SHIFT;
            tx_bit_q <= tx_nine ? 4'd10 : 4'd9;
            if (ctrl2_q[asc_pkg::C2_SBK]) begin
              tx_sh_q <= 11'h000;
            end else if (ctrl1_q[asc_pkg::C1_PEN]) begin
              tx_sh_q <= tx_nine ? {1'b1, tx_par, tx_data_q, 1'b0}
                                 : {2'b11, tx_par, tx_data_q[6:0], 1'b0};
            end else begin
              tx_sh_q <= {1'b1, tx_nine ? ctrl3_q[asc_pkg::C3_T8] : 1'b1,
                          tx_data_q, 1'b0};
            end
          end
        end
        ASC_TX_SHIFT: begin
          if (tx_bit_end) begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q - 4'h1;
            if (tx_bit_q == 4'h0) begin
              tx_st_q <= ASC_TX_IDLE;
            end
          end
        end
        default: tx_st_q <= ASC_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      txd <= 1'b1;
    end else begin
      txd <= (tx_st_q == ASC_TX_SHIFT) ? tx_sh_q[0] : 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_complete_flag_q <= 1'b1;
    end else begin
      tx_complete_flag_q <= tx_empty_flag_q && !tx_pend_q
                            && tx_st_q == ASC_TX_IDLE
                            && !(ctrl2_q[asc_pkg::C2_TE]
                                 && ctrl2_q[asc_pkg::C2_SBK]);
    end
  end

  // Receiver: sixteen samples per bit, majority of samples 7, 8, 9.
  logic [3:0] rx_sub_q;
  logic [3:0] rx_bit_q;
  logic [9:0] rx_sh_q;
  logic [2:0] rx_smp_q;
  logic       rx_act_q, rx_in_progress_flag_q, rx_noise_q, rx_seen_q;
  logic [3:0] idle_cnt_q;
  logic       idle_arm_q, brk_ok_q;
  logic       rx_done, rx_maj, rx_mid, rx_nbits_last;
  logic [9:0] rx_word;
  logic       rx_brk, rx_par_bad, rx_stop_bad;
  logic       rx_full_flag, idle_flag, or_flag, nf_flag, fe_flag, pe_flag;
  logic       brk_flag, rx_ena, rx_ninth_bit_q;
  logic       set_full, set_or, set_idle, idle_clr;

  assign rx_ena  = ctrl2_q[asc_pkg::C2_RE];
  assign rx_maj  = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_smp_q[2])
                   | (rx_smp_q[1] & rx_smp_q[2]);
  assign rx_mid  = tk.sample_tick && rx_act_q && rx_sub_q == 4'd10;
  assign rx_nbits_last = rx_bit_q == (tx_nine ? 4'd10 : 4'd9);
  assign rx_done = rx_mid && rx_nbits_last;
  assign rx_word = {rx_maj, rx_sh_q[9:1]};
  assign rx_brk  = rx_done && rx_word == 10'h000 && !rx_maj;
  assign rx_stop_bad = rx_done && !rx_maj;
  assign rx_par_bad  = rx_done && ctrl1_q[asc_pkg::C1_PEN]
    && ((tx_nine ? ^rx_sh_q[9:1] : ^rx_sh_q[9:2])
        != ctrl1_q[asc_pkg::C1_PTY]);
  assign set_full = rx_done && !rx_full_flag;
  assign set_or   = rx_done && rx_full_flag;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_act_q <= 1'b0;
      rx_in_progress_flag_q <= 1'b0;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_smp_q <= 3'h7;
      rx_noise_q <= 1'b0;
    end else if (!rx_ena) begin
      rx_act_q <= 1'b0;
      rx_in_progress_flag_q <= 1'b0;
    end else if (tk.sample_tick) begin
      if (!rx_act_q) begin
        if (!rxd) begin
          rx_act_q <= 1'b1;
          rx_in_progress_flag_q <= 1'b1;
          rx_sub_q <= 4'h2;
          rx_bit_q <= 4'h0;
          rx_noise_q <= 1'b0;
        end
      end else begin
        rx_sub_q <= rx_sub_q + 4'h1;
        if (rx_sub_q >= 4'd7 && rx_sub_q <= 4'd9) begin
          rx_smp_q <= {rx_smp_q[1:0], rxd};
        end
        if (rx_mid) begin
          if (rx_smp_q != 3'h0 && rx_smp_q != 3'h7) begin
            rx_noise_q <= 1'b1;
          end
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rx_maj) begin
            rx_act_q <= 1'b0;
            rx_in_progress_flag_q <= 1'b0;
          end else if (rx_nbits_last) begin
            rx_act_q <= 1'b0;
          end
        end
      end
    end
    if (rst_b && set_idle) begin
      rx_in_progress_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rx_mid) begin
      rx_sh_q <= {rx_maj, rx_sh_q[9:1]};
    end
  end

  // Old data stays when the new character overruns.
  always_ff @(posedge sys_clk) begin
    if (set_full) begin
      rx_data_q <= tx_nine ? rx_word[7:0] : rx_word[8:1];
      rx_ninth_bit_q <= tx_nine ? (rx_brk ? 1'b0 : rx_word[8])
                                : rx_word[8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      idle_cnt_q <= 4'h0;
    end else if (!rx_ena || rx_act_q || !rxd) begin
      idle_cnt_q <= 4'h0;
    end else if (tk.sample_tick && tx_sub_q == 4'hf
                 && idle_cnt_q != 4'hf) begin
      idle_cnt_q <= idle_cnt_q + 4'h1;
    end
  end

  assign set_idle = idle_arm_q && idle_cnt_q == 4'd10
                    && tk.sample_tick && tx_sub_q == 4'hf;
  assign idle_clr = idle_flag && !set_idle && data_rd;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      idle_arm_q <= 1'b0;
    end else if (!rx_ena || set_idle || idle_clr) begin
      idle_arm_q <= 1'b0;
    end else if (set_full) begin
      idle_arm_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      brk_ok_q <= 1'b1;
    end else if (rx_brk) begin
      brk_ok_q <= 1'b0;
    end else if (rx_ena && rxd && !rx_act_q) begin
      brk_ok_q <= 1'b1;
    end
  end

  asc_flag u_full (.sys_clk(sys_clk), .rst_b(rst_b), .set_evt(set_full),
                   .stat_rd(st1_rd), .data_rd(data_rd),
                   .flag_q(rx_full_flag));
  asc_flag u_idle (.sys_clk(sys_clk), .rst_b(rst_b), .set_evt(set_idle),
                   .stat_rd(st1_rd), .data_rd(data_rd),
                   .flag_q(idle_flag));
  asc_flag u_or (.sys_clk(sys_clk), .rst_b(rst_b), .set_evt(set_or),
                 .stat_rd(st1_rd), .data_rd(data_rd),
                 .flag_q(or_flag));
  asc_flag u_nf (.sys_clk(sys_clk), .rst_b(rst_b),
                 .set_evt(rx_done && (rx_noise_q || rx_mid_noise(rx_smp_q))),
                 .stat_rd(st1_rd), .data_rd(data_rd),
                 .flag_q(nf_flag));
  asc_flag u_fe (.sys_clk(sys_clk), .rst_b(rst_b), .set_evt(rx_stop_bad),
                 .stat_rd(st1_rd), .data_rd(data_rd),
                 .flag_q(fe_flag));
  asc_flag u_pe (.sys_clk(sys_clk), .rst_b(rst_b), .set_evt(rx_par_bad),
                 .stat_rd(st1_rd), .data_rd(data_rd),
                 .flag_q(pe_flag));
  asc_flag u_bk (.sys_clk(sys_clk), .rst_b(rst_b),
                 .set_evt(rx_brk && brk_ok_q),
                 .stat_rd(st2_rd), .data_rd(data_rd),
                 .flag_q(brk_flag));

  function automatic logic rx_mid_noise(input logic [2:0] s);
    rx_mid_noise = (s != 3'h0) && (s != 3'h7);
  endfunction

  assign stat1 = {tx_empty_flag_q, tx_complete_flag_q, rx_full_flag,
                  idle_flag, or_flag, nf_flag, fe_flag, pe_flag};
  assign stat2 = {6'h00, brk_flag, rx_in_progress_flag_q};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == asc_pkg::OFF_DATA) begin
        prdata <= {24'h000000, rx_data_q};
      end else if (paddr == asc_pkg::OFF_STAT1) begin
        prdata <= {24'h000000, stat1};
      end else if (paddr == asc_pkg::OFF_STAT2) begin
        prdata <= {24'h000000, stat2};
      end else if (paddr == asc_pkg::OFF_CTRL1) begin
        prdata <= {24'h000000, ctrl1_q};
      end else if (paddr == asc_pkg::OFF_CTRL2) begin
        prdata <= {24'h000000, ctrl2_q};
      end else if (paddr == asc_pkg::OFF_CTRL3) begin
        prdata <= {24'h000000, rx_ninth_bit_q, ctrl3_q[6:0]};
      end else if (paddr == asc_pkg::OFF_RATE) begin
        prdata <= {24'h000000, rate_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  assign tx_irq  = tx_complete_flag_q && ctrl2_q[asc_pkg::C2_TX_COMPLETE_IRQ_EN];
  assign rx_irq  = (rx_full_flag && ctrl2_q[asc_pkg::C2_RIE])
                   || (idle_flag && ctrl2_q[asc_pkg::C2_IDLE_LINE_IRQ_EN]);
  assign err_irq = (or_flag && ctrl3_q[asc_pkg::C3_RX_OVERRUN_IRQ_EN])
                   || (nf_flag && ctrl3_q[asc_pkg::C3_RX_NOISE_IRQ_EN])
                   || (fe_flag && ctrl3_q[asc_pkg::C3_RX_FRAMING_IRQ_EN])
                   || (pe_flag && ctrl3_q[asc_pkg::C3_RX_PARITY_IRQ_EN]);
endmodule
`default_nettype wire

// ---- testbench/asc_core_properties.sv ----
/*
  Port checks for asc_core.
  Assumes it is bound to asc_core with every port joined by name.
*/
`timescale 1ns/10ps
`default_nettype none
module asc_core_properties (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        err_irq
);
  logic [15:0] low_q;
  logic        acc;
  logic        rd_data;
  assign acc = psel && penable;
  assign rd_data = acc && !pwrite && paddr == asc_pkg::OFF_DATA;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Counts the cycles that txd has stayed low.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || txd) begin
      low_q <= 16'h0;
    end else begin
      low_q <= low_q + 16'h1;
    end
  end
  reset_out_a:
    assert property (disable iff (1'b0) !rst_b |=> txd && !tx_irq
      && !rx_irq && !err_irq) else $error("Outputs busy after reset.");
  tc_empty_a:
    assert property (acc && !pwrite && paddr == asc_pkg::OFF_STAT1
      && prdata[asc_pkg::ST1_TC] |-> prdata[asc_pkg::ST1_TE])
      else $error("Complete without empty.");
  tc_line_a:
    assert property (tx_irq |-> txd) else $error("Complete while sending.");
  rx_clear_a:
    assert property ($fell(rx_irq) |-> $past(rd_data || acc && pwrite
      && paddr == asc_pkg::OFF_CTRL2)) else $error("Receive request lost.");
  err_clear_a:
    assert property ($fell(err_irq) |-> $past(rd_data || acc && pwrite
      && paddr == asc_pkg::OFF_CTRL3)) else $error("Error request lost.");
  bit_time_a:
    assert property ($rose(txd) |-> low_q != 16'h0 && low_q[5:0] == 6'h0)
      else $error("Low time not whole bits.");
  stat2_bits_a:
    assert property (acc && !pwrite && paddr == asc_pkg::OFF_STAT2
      |-> prdata[31:2] == 30'h0) else $error("Status two spare bits set.");
  upper_zero_a:
    assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("Upper read bits set.");
  refuse_a:
    assert property (acc && (paddr > asc_pkg::OFF_DATA || pwrite
      && paddr == asc_pkg::OFF_STAT1) |-> pslverr && pready)
      else $error("Bad access not refused.");
  cover property ($rose(rx_irq));
  cover property ($rose(err_irq));
  cover property ($fell(tx_irq));
endmodule
`default_nettype wire

// ---- testbench/asc_peer.sv ----
/*
  Serial peer that sends frames into the receive line of the block.
  Assumes eight-bit frames and a bit of BIT_CYC clock cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module asc_peer #(
  parameter int BIT_CYC = 64
) (
  input  wire logic sys_clk,
  output logic      rxd
);
  // The line idles high, as a pulled-up receive pin would.
  initial rxd = 1'b1;
  // Sends a start bit, eight bits LSB first, then the given stop level.
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/asc_core_tb_top.sv ----
/*
  Self-checking bench for asc_core with a serial peer on the receive line.
  Assumes the reset rate gives a bit of 64 clock cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module asc_core_tb_top;
  localparam logic [7:0] s1 = asc_pkg::OFF_STAT1;
  localparam logic [7:0] s2 = asc_pkg::OFF_STAT2;
  localparam logic [7:0] da = asc_pkg::OFF_DATA;
  localparam logic [7:0] c2 = asc_pkg::OFF_CTRL2;
  localparam logic [7:0] c3 = asc_pkg::OFF_CTRL3;
  localparam logic [7:0] rt = asc_pkg::OFF_RATE;
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        tx_irq;
  logic        rx_irq;
  logic        err_irq;
  logic [31:0] v;
  logic        slverr;
  int          checks = 0;
  int          err_total = 0;
  int          cyc = 0;
  asc_core DUT (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .tx_irq, .rx_irq,
    .err_irq);
  asc_peer peer (.sys_clk, .rxd);
  always #2.5 sys_clk = ~sys_clk;
  task automatic end_of_test;
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    v = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic bits(input int n);
    repeat (n * 64) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    apb(0, s1, 0); `CHK(v, 32'hc0)
    apb(0, s2, 0); `CHK(v, 32'h0)
    apb(0, rt, 0); `CHK(v, 32'h0)
    apb(1, rt, 8'hff); apb(0, rt, 0); `CHK(v, 32'h37)
    apb(0, 8'h1c, 0); `CHK(slverr, 1'b1)
    apb(1, rt, 8'h00);
  endtask
  task automatic t_rx;
    apb(1, c2, 8'h34);
    apb(1, c3, 8'h0f);
    peer.send(8'ha5, 1'b1);
    `CHK(rx_irq, 1'b1)
    apb(0, s1, 0); `CHK(v[5:4], 2'h2)
    apb(0, da, 0); `CHK(v[7:0], 8'ha5)
    bits(12); apb(0, s1, 0); `CHK(v[5:4], 2'h1)
    apb(0, da, 0); `CHK(rx_irq, 1'b0)
    bits(12); apb(0, s1, 0); `CHK(v[4], 1'b0)
  endtask
  task automatic t_ovr;
    peer.send(8'h11, 1'b1);
    peer.send(8'h22, 1'b1);
    `CHK(err_irq, 1'b1)
    apb(0, s1, 0); `CHK(v[5:3], 3'h5)
    apb(0, da, 0); `CHK(v[7:0], 8'h11)
    `CHK(err_irq, 1'b0)
    peer.send(8'h33, 1'b1);
    apb(0, s1, 0);
    peer.send(8'h44, 1'b1);
    apb(0, da, 0); `CHK(v[7:0], 8'h33)
    apb(0, s1, 0); `CHK(v[3], 1'b1)
    apb(0, da, 0); apb(0, s1, 0); `CHK(v[5:3], 3'h0)
  endtask
  task automatic t_frame;
    fork
      peer.send(8'h55, 1'b0);
      begin
        bits(3);
        apb(0, s2, 0); `CHK(v[0], 1'b1)
      end
    join
    apb(0, s1, 0); `CHK(v[1], 1'b1)
    apb(0, da, 0); apb(0, s1, 0); `CHK(v[1], 1'b0)
    peer.send(8'h00, 1'b0);
    apb(0, s2, 0); `CHK(v[1], 1'b1)
    apb(0, s1, 0); `CHK({v[5], v[1]}, 2'h3)
    apb(0, da, 0); apb(0, s2, 0); `CHK(v[1], 1'b0)
  endtask
  task automatic t_tx;
    int         n;
    logic [9:0] f;
    f = {1'b1, 8'h96, 1'b0};
    apb(1, rt, 8'h01);
    apb(1, c2, 8'h48);
    repeat (1536) @(posedge sys_clk);
    while (tx_irq !== 1'b1) @(posedge sys_clk);
    apb(1, da, 8'h96);
    n = 0;
    while (txd !== 1'b0) begin
      n++;
      @(posedge sys_clk);
    end
    `CHK(n <= 192, 1'b1)
    `CHK(tx_irq, 1'b0)
    repeat (64) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      `CHK(txd, f[i])
      repeat (128) @(posedge sys_clk);
    end
    `CHK(tx_irq, 1'b1)
    apb(1, c2, 8'h08); `CHK(tx_irq, 1'b0)
    apb(0, s1, 0); `CHK(v[7:6], 2'h3)
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_rx();
    t_ovr();
    t_frame();
    t_tx();
    end_of_test();
  end
endmodule
bind asc_core asc_core_properties chk (.sys_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .txd, .tx_irq, .rx_irq,
  .err_irq);
`default_nettype wire
